// ### design/itr_ctl.v
// Functional notes
// - bypass low: init writes wait for idle line
// - bypass high: init ignores line activity
// - id write: d1 to 000, id to 001
// - refinement off keeps legacy timing and logic
// - clear commands or successor read drop interrupt
// - legacy interrupt gap scales with data rate
// - refined interrupt gap on fixed 20 MHz
// - refined prescaler select passes synchroniser
// - legacy command gap scales with data rate
// - refined command gap from crystal clock
// - legacy enable commands prohibited after status rise
// - refined status rises at set pulse end
// - refined id writes clear stale probe effects
// - refined mask also cleared by soft reset
// - soft reset on id zero or reset bit
// - soft reset sets both status bits high
// - arbitration base doubles with slow arbitration
`include "itr_map.vh"

module itr_ctl
(
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// mode bits
	input wire initWaitBypass,
	input wire refinementEnable,
	input wire slowArbitration,
	input wire cfgResetBit,
	// rate clocks as ticks
	input wire rateOscTick,
	input wire preTick,
	// line and microprogram
	input wire lineIdle,
	// identifier writes
	input wire stationIdWr,
	input wire [7:0] stationIdData,
	input wire probeIdWr,
	// command writes and interrupt causes
	input wire cmdWr,
	input wire cmdEnableTx,
	input wire cmdEnableRx,
	input wire cmdClearInt,
	input wire successorRd,
	input wire intRequest,
	// status set pulses
	input wire txSetPulse,
	input wire rxSetPulse,
	// mask and prescaler writes
	input wire maskWr,
	input wire [7:0] maskData,
	input wire [2:0] prescalerSelectIn,
	// ram write port
	output reg ramWe_r,
	output reg [10:0] ramAddr_r,
	output reg [7:0] ramData_r,
	output reg initDone_r,
	// interrupt
	output reg interruptOutN_r,
	// command handling
	output reg cmdAccept_r,
	output reg cmdRefused_r,
	// status and mask
	output reg transmitterAvailable_r,
	output reg receiverInhibited_r,
	output reg [7:0] mask_r,
	// other outputs
	output reg residualClear_r,
	output reg softReset_r,
	output reg arbTick_r,
	output wire [2:0] prescalerSelect
);

	// ****************************************
	// helpers
	// ****************************************
	// timing tick: crystal when refined, rate oscillator when legacy
	function pickTick;
		input ef;
		input xtal;
		input osc;
		begin
			pickTick = ef ? xtal : osc;
		end
	endfunction

	localparam S_IDLE = 2'h0;
	localparam S_WAIT = 2'h1;
	localparam S_WR0 = 2'h2;
	localparam S_WR1 = 2'h3;

	reg [`ITR_XTAL_ACC_W-1:0] xtalAcc_r;
	reg xtalTick_r;
	reg arbHalf_r;
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [7:0] idLatch_r;
	reg cfgResetD_r;
	reg [2:0] intDisCnt_r;
	reg [2:0] cmdGapCnt_r;
	reg acceptTx_r;
	reg acceptRx_r;
	reg [2:0] prohibitCnt_r;
	reg txPulseD_r;
	reg rxPulseD_r;
	reg [2:0] presetLegacy_r;
	wire [2:0] presetSynced;
	wire [`ITR_XTAL_ACC_W-1:0] xtalSum;
	wire softEvent;
	wire intKick;
	wire timeTick;
	wire txRise;
	wire rxRise;
	wire txFall;
	wire rxFall;
	wire txReturn;
	wire rxReturn;
	wire enableCmd;

	// ****************************************
	// 20 MHz crystal tick from system clock
	// ****************************************
	// fractional step keeps the long-run rate exact, jitter is one cycle
	assign xtalSum = xtalAcc_r + `ITR_XTAL_STEP;

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			xtalAcc_r <= {`ITR_XTAL_ACC_W{1'b0}};
			xtalTick_r <= 1'b0;
		end
		else if (xtalSum >= `ITR_XTAL_MOD)
		begin
			xtalAcc_r <= xtalSum - `ITR_XTAL_MOD;
			xtalTick_r <= 1'b1;
		end
		else
		begin
			xtalAcc_r <= xtalSum;
			xtalTick_r <= 1'b0;
		end
	end

	// ****************************************
	// arbitration time base
	// ****************************************
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			arbHalf_r <= 1'b0;
			arbTick_r <= 1'b0;
		end
		else
		begin
			if (rateOscTick)
				arbHalf_r <= ~arbHalf_r;
			arbTick_r <= rateOscTick & (~slowArbitration | arbHalf_r);
		end
	end

	// ****************************************
	// soft reset detection
	// ****************************************
	assign softEvent = (stationIdWr && stationIdData == `ITR_SOFT_RST_ID)
		|| (cfgResetBit && !cfgResetD_r);

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfgResetD_r <= 1'b0;
			softReset_r <= 1'b0;
			residualClear_r <= 1'b0;
		end
		else
		begin
			cfgResetD_r <= cfgResetBit;
			softReset_r <= softEvent;
			// legacy leaves stale probe effects to age out
			residualClear_r <= refinementEnable
				& (probeIdWr | stationIdWr);
		end
	end

	// ****************************************
	// ram initialisation sequence
	// ****************************************
	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE:
				if (stationIdWr)
					state_nxt = S_WAIT;
			S_WAIT:
				// bypass decodes the init routine and skips the idle wait
				if (initWaitBypass || lineIdle)
					state_nxt = S_WR0;
			S_WR0:
				state_nxt = S_WR1;
			S_WR1:
				state_nxt = S_IDLE;
			default:
				state_nxt = S_IDLE;
		endcase
	end

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= S_IDLE;
			idLatch_r <= 8'h00;
			ramWe_r <= 1'b0;
			ramAddr_r <= `ITR_INIT_ADDR0;
			ramData_r <= 8'h00;
			initDone_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			if (stationIdWr)
			begin
				idLatch_r <= stationIdData;
				initDone_r <= 1'b0;
			end
			ramWe_r <= 1'b0;
			if (state_r == S_WR0)
			begin
				ramWe_r <= 1'b1;
				ramAddr_r <= `ITR_INIT_ADDR0;
				ramData_r <= `ITR_INIT_DATA0;
			end
			else if (state_r == S_WR1)
			begin
				ramWe_r <= 1'b1;
				ramAddr_r <= `ITR_INIT_ADDR1;
				ramData_r <= idLatch_r;
				initDone_r <= 1'b1;
			end
		end
	end

	// ****************************************
	// interrupt disable window
	// ****************************************
	assign intKick = (cmdWr & cmdClearInt) | successorRd;
	assign timeTick = pickTick(refinementEnable, xtalTick_r, rateOscTick);

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			intDisCnt_r <= 3'h0;
			interruptOutN_r <= 1'b1;
		end
		else
		begin
			if (intKick && !interruptOutN_r)
				intDisCnt_r <= refinementEnable ? `ITR_INT_DIS_XTAL
					: `ITR_INT_DIS_OSC;
			else if (intDisCnt_r != 3'h0 && timeTick)
				intDisCnt_r <= intDisCnt_r - 3'h1;
			interruptOutN_r <= ~(intRequest && intDisCnt_r == 3'h0
				&& !(intKick && !interruptOutN_r));
		end
	end

	// ****************************************
	// command write interval and prohibition
	// ****************************************
	assign enableCmd = cmdEnableTx | cmdEnableRx;

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmdGapCnt_r <= 3'h0;
			cmdAccept_r <= 1'b0;
			cmdRefused_r <= 1'b0;
			acceptTx_r <= 1'b0;
			acceptRx_r <= 1'b0;
		end
		else
		begin
			cmdAccept_r <= 1'b0;
			cmdRefused_r <= 1'b0;
			acceptTx_r <= 1'b0;
			acceptRx_r <= 1'b0;
			if (cmdWr && (cmdGapCnt_r != 3'h0
				|| (enableCmd && prohibitCnt_r != 3'h0)))
				cmdRefused_r <= 1'b1;
			else if (cmdWr)
			begin
				cmdAccept_r <= 1'b1;
				// qualifiers are gone once the host drops the strobe
				acceptTx_r <= cmdEnableTx;
				acceptRx_r <= cmdEnableRx;
				cmdGapCnt_r <= `ITR_CMD_GAP_TICKS;
			end
			else if (cmdGapCnt_r != 3'h0
				&& pickTick(refinementEnable, xtalTick_r, rateOscTick))
				cmdGapCnt_r <= cmdGapCnt_r - 3'h1;
		end
	end

	// ****************************************
	// transmitter and receiver status bits
	// ****************************************
	assign txRise = txSetPulse & ~txPulseD_r;
	assign rxRise = rxSetPulse & ~rxPulseD_r;
	assign txFall = ~txSetPulse & txPulseD_r;
	assign rxFall = ~rxSetPulse & rxPulseD_r;
	// legacy returns high at pulse start, refined at its end
	assign txReturn = refinementEnable ? txFall : txRise;
	assign rxReturn = refinementEnable ? rxFall : rxRise;

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txPulseD_r <= 1'b0;
			rxPulseD_r <= 1'b0;
			transmitterAvailable_r <= 1'b1;
			receiverInhibited_r <= 1'b1;
			prohibitCnt_r <= 3'h0;
		end
		else
		begin
			txPulseD_r <= txSetPulse;
			rxPulseD_r <= rxSetPulse;
			if (softEvent)
			begin
				transmitterAvailable_r <= 1'b1;
				receiverInhibited_r <= 1'b1;
			end
			else
			begin
				if (txReturn)
					transmitterAvailable_r <= 1'b1;
				else if (acceptTx_r)
					transmitterAvailable_r <= 1'b0;
				if (rxReturn)
					receiverInhibited_r <= 1'b1;
				else if (acceptRx_r)
					receiverInhibited_r <= 1'b0;
			end
			// the pulse still running after the rise is the hazard
			if (!refinementEnable && (txRise || rxRise))
				prohibitCnt_r <= `ITR_PROHIBIT_OSC;
			else if (refinementEnable)
				prohibitCnt_r <= 3'h0;
			else if (prohibitCnt_r != 3'h0 && rateOscTick)
				prohibitCnt_r <= prohibitCnt_r - 3'h1;
		end
	end

	// ****************************************
	// interrupt mask
	// ****************************************
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			mask_r <= `ITR_MASK_RST;
		else if (softEvent && refinementEnable)
			mask_r <= `ITR_MASK_RST;
		else if (maskWr)
			mask_r <= maskData;
	end

	// ****************************************
	// prescaler select path
	// ****************************************
	// legacy path is a plain copy, free to glitch the divided clock
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			presetLegacy_r <= `ITR_PRESEL_RST;
		else
			presetLegacy_r <= prescalerSelectIn;
	end

	itr_sync uSync
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.preTick(preTick),
		.selIn(prescalerSelectIn),
		.selOut_r(presetSynced)
	);

	// host keeps select at zero above 5 Mbps, so no guard here
	assign prescalerSelect = refinementEnable ? presetSynced
		: presetLegacy_r;

endmodule // itr_ctl

// ### design/itr_sync.v
// ****************************************
// prescaler select synchroniser
// ****************************************
`include "itr_map.vh"

module itr_sync
(
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// prescaler internal clock as a tick
	input wire preTick,
	// select word in and out
	input wire [2:0] selIn,
	output reg [2:0] selOut_r
);

	reg [2:0] stage1_r;
	reg [2:0] stage2_r;
	reg [2:0] stage3_r;

	// stage1 is read only by stage2; stage3 compares settled copies
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1_r <= `ITR_PRESEL_RST;
			stage2_r <= `ITR_PRESEL_RST;
			stage3_r <= `ITR_PRESEL_RST;
			selOut_r <= `ITR_PRESEL_RST;
		end
		else if (preTick)
		begin
			stage1_r <= selIn;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
			if (stage2_r == stage3_r)
				selOut_r <= stage3_r;
		end
	end

endmodule // itr_sync

// ### shared/itr_map.vh
`ifndef ITR_MAP_VH
`define ITR_MAP_VH

// ****************************************
// init sequence ram image
// ****************************************
`define ITR_INIT_ADDR0 11'h000
`define ITR_INIT_ADDR1 11'h001
`define ITR_INIT_DATA0 8'hd1
`define ITR_SOFT_RST_ID 8'h00
`define ITR_INIT_LIMIT_NS 3000

// ****************************************
// clocks and timing
// ****************************************
`define ITR_SYS_MHZ 125
`define ITR_XTAL_MHZ 20
`define ITR_XTAL_ACC_W 5
`define ITR_XTAL_STEP 5'h04
`define ITR_XTAL_MOD 5'h19
`define ITR_CMD_GAP_NS 100
`define ITR_CMD_GAP_TICKS 3'h2
`define ITR_INT_DIS_NS 200
`define ITR_INT_DIS_OSC 3'h4
`define ITR_INT_DIS_XTAL 3'h5
`define ITR_PROHIBIT_NS 3200
`define ITR_PROHIBIT_OSC 3'h4

// ****************************************
// reset values
// ****************************************
`define ITR_MASK_RST 8'h00
`define ITR_PRESEL_RST 3'h0

`endif

// ### testbench/itr_ctl_properties.sv
// ****
// port properties of the control block
// ****
module itr_ctl_properties
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// inputs
	input wire logic initWaitBypass,
	input wire logic refinementEnable,
	input wire logic cfgResetBit,
	input wire logic lineIdle,
	input wire logic stationIdWr,
	input wire logic probeIdWr,
	input wire logic cmdWr,
	input wire logic cmdClearInt,
	input wire logic successorRd,
	input wire logic [2:0] prescalerSelectIn,
	// outputs
	input wire logic ramWe_r,
	input wire logic [10:0] ramAddr_r,
	input wire logic [7:0] ramData_r,
	input wire logic initDone_r,
	input wire logic interruptOutN_r,
	input wire logic cmdAccept_r,
	input wire logic cmdRefused_r,
	input wire logic transmitterAvailable_r,
	input wire logic receiverInhibited_r,
	input wire logic residualClear_r,
	input wire logic [2:0] prescalerSelect
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	wire clrEv = ((cmdWr && cmdClearInt) || successorRd) && !interruptOutN_r;
	chk_init_image: assert property (
		(ramWe_r && ramAddr_r == 11'h000) |-> (ramData_r == 8'hd1)
		##1 (ramWe_r && ramAddr_r == 11'h001 && initDone_r))
		else $error("init image wrong");
	// the wait state decided two edges before the first write shows
	chk_init_wait: assert property (
		(ramWe_r && ramAddr_r == 11'h000)
		|-> ($past(lineIdle, 2) || $past(initWaitBypass, 2)))
		else $error("init write on busy line");
	chk_int_clear: assert property (clrEv |=> interruptOutN_r)
		else $error("interrupt not dropped");
	chk_int_gap: assert property (
		clrEv && refinementEnable |=> interruptOutN_r[*8]
		##1 interruptOutN_r[*8] ##1 interruptOutN_r[*8])
		else $error("refined interrupt gap short");
	chk_cmd_gap: assert property (
		cmdAccept_r && cmdWr |=> cmdRefused_r && !cmdAccept_r)
		else $error("command inside gap taken");
	chk_soft_status: assert property (
		$rose(cfgResetBit)
		|-> ##[1:2] (transmitterAvailable_r && receiverInhibited_r))
		else $error("soft reset status wrong");
	chk_residual_clr: assert property (
		probeIdWr || stationIdWr
		|=> residualClear_r == $past(refinementEnable))
		else $error("residual clear wrong");
	chk_presel_hold: assert property (
		refinementEnable && $changed(prescalerSelectIn)
		|=> $stable(prescalerSelect)[*2])
		else $error("select passed unsynchronised");
	cover property (ramWe_r && ramAddr_r == 11'h001);
	cover property (clrEv && refinementEnable);
	cover property (cmdRefused_r);
endmodule // itr_ctl_properties

bind itr_ctl itr_ctl_properties i_props (.*);

// ### testbench/itr_host_model.sv
// ****
// host cpu side
// ****
module itr_host_model
(
	// clock
	input wire logic clk_sys,
	// host writes and reads
	output logic stationIdWr,
	output logic [7:0] stationIdData,
	output logic cmdWr,
	output logic cmdEnableTx,
	output logic cmdClearInt,
	output logic successorRd,
	output logic [2:0] prescalerSelectIn
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		{stationIdWr, stationIdData, cmdWr, cmdEnableTx} = 11'h000;
		{cmdClearInt, successorRd, prescalerSelectIn} = 5'h00;
	end
	task automatic wrId(input logic [7:0] v);
		@(negedge clk_sys);
		{stationIdWr, stationIdData} = {1'b1, v};
		@(negedge clk_sys);
		stationIdWr = 1'b0;
	endtask
	// n writes back to back, qualifiers held throughout
	task automatic wrCmd(input logic tx, input logic clr, input int n);
		@(negedge clk_sys);
		{cmdWr, cmdEnableTx, cmdClearInt} = {1'b1, tx, clr};
		repeat (n) @(negedge clk_sys);
		{cmdWr, cmdEnableTx, cmdClearInt} = 3'h0;
	endtask
	task automatic rdNext;
		@(negedge clk_sys);
		successorRd = 1'b1;
		@(negedge clk_sys);
		successorRd = 1'b0;
	endtask
	// bench rate is low, so a nonzero select is legal here
	task automatic setSel(input logic [2:0] v);
		@(negedge clk_sys);
		prescalerSelectIn = v;
	endtask
endmodule // itr_host_model

// ### testbench/test_init_and_timing_refinement_ctl.sv
module test_init_and_timing_refinement_ctl;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0, rst_n = 1'b0, initWaitBypass = 1'b1;
	logic refinementEnable = 1'b0, cfgResetBit = 1'b0, lineIdle = 1'b1;
	logic slowArbitration = 1'b0, rateOscTick = 1'b0, preTick = 1'b0;
	logic probeIdWr = 1'b0, cmdEnableRx = 1'b0, intRequest = 1'b0;
	logic txSetPulse = 1'b0, rxSetPulse = 1'b0, maskWr = 1'b0;
	logic stationIdWr, cmdWr, cmdEnableTx, cmdClearInt, successorRd;
	logic ramWe_r, initDone_r, interruptOutN_r, cmdAccept_r, cmdRefused_r;
	logic transmitterAvailable_r, receiverInhibited_r, residualClear_r;
	logic softReset_r, arbTick_r;
	logic [7:0] maskData = 8'hff, cyc = 8'h00;
	logic [7:0] stationIdData, ramData_r, mask_r;
	logic [2:0] prescalerSelectIn, prescalerSelect;
	logic [10:0] ramAddr_r;
	logic [10:0] arbCnt = 11'h000, arbMark = 11'h000;
	int failures = 0, totalChecks = 0;
	// ef, bypass, idle, id, expected residual clear
	logic [11:0] rows [4] = '{12'h4b4, 12'hd4b, 12'h3fe, 12'ha03};
	always #4 clk_sys = ~clk_sys;
	// oscillator tick every 8 cycles, prescaler tick every 4
	always @(negedge clk_sys)
	begin
		cyc <= cyc + 8'h01;
		rateOscTick <= (cyc[2:0] == 3'h0);
		preTick <= (cyc[1:0] == 2'h1);
		arbCnt <= arbCnt + {10'h000, arbTick_r};
	end
	itr_ctl i_dut (.*);
	itr_host_model i_host (.*);
	task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
		totalChecks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic waitWe(input logic [7:0] id);
		int n;
		n = 0;
		while (ramWe_r !== 1'b1 && n < 60)
		begin
			tick(1);
			n++;
		end
		chk({ramWe_r, ramData_r, ramAddr_r[1:0]}, 11'h744);
		tick(1);
		chk({ramWe_r, initDone_r, ramData_r}, {2'h3, id});
		chk(ramAddr_r, 11'h001);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", totalChecks, failures);
		if (failures == 0 && totalChecks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#100us;
		failures++;
		tally_and_finish;
	end
	initial
	begin
		tick(1);
		chk({interruptOutN_r, transmitterAvailable_r}, 11'h003);
		tick(5);
		rst_n = 1'b1;
		foreach (rows[k])
		begin
			tick(20);
			{refinementEnable, initWaitBypass, lineIdle} = rows[k][11:9];
			i_host.wrId(rows[k][8:1]);
			chk(residualClear_r, rows[k][0]);
			waitWe(rows[k][8:1]);
		end
		{refinementEnable, initWaitBypass, lineIdle} = 3'h0;
		i_host.wrId(8'h33);
		repeat (20)
		begin
			tick(1);
			chk(ramWe_r, 11'h000);
		end
		lineIdle = 1'b1;
		waitWe(8'h33);
		{intRequest, refinementEnable} = 2'h3;
		tick(3);
		chk(interruptOutN_r, 11'h000);
		i_host.rdNext();
		// 26 cycles of 8 ns prove the gap is above 200 ns
		repeat (26)
		begin
			chk(interruptOutN_r, 11'h001);
			tick(1);
		end
		refinementEnable = 1'b0;
		tick(40);
		i_host.wrCmd(1'b0, 1'b1, 1);
		repeat (24)
		begin
			chk(interruptOutN_r, 11'h001);
			tick(1);
		end
		// four oscillator ticks are over by now
		tick(9);
		chk(interruptOutN_r, 11'h000);
		intRequest = 1'b0;
		tick(30);
		i_host.wrCmd(1'b1, 1'b0, 1);
		chk(cmdAccept_r, 11'h001);
		tick(2);
		chk(transmitterAvailable_r, 11'h000);
		txSetPulse = 1'b1;
		tick(3);
		chk(transmitterAvailable_r, 11'h001);
		txSetPulse = 1'b0;
		tick(12);
		i_host.wrCmd(1'b1, 1'b0, 1);
		chk(cmdRefused_r, 11'h001);
		refinementEnable = 1'b1;
		tick(40);
		i_host.wrCmd(1'b1, 1'b0, 2);
		chk(cmdRefused_r, 11'h001);
		tick(12);
		txSetPulse = 1'b1;
		tick(3);
		chk(transmitterAvailable_r, 11'h000);
		txSetPulse = 1'b0;
		tick(2);
		chk(transmitterAvailable_r, 11'h001);
		i_host.wrCmd(1'b1, 1'b0, 1);
		chk(cmdAccept_r, 11'h001);
		tick(3);
		maskWr = 1'b1;
		tick(1);
		{maskWr, refinementEnable, cfgResetBit} = 3'h1;
		tick(1);
		chk(softReset_r, 11'h001);
		tick(2);
		chk(mask_r, 11'h0ff);
		chk({transmitterAvailable_r, receiverInhibited_r}, 11'h003);
		{refinementEnable, cfgResetBit} = 2'h2;
		tick(2);
		cfgResetBit = 1'b1;
		tick(3);
		chk(mask_r, 11'h000);
		cfgResetBit = 1'b0;
		i_host.setSel(3'h5);
		tick(1);
		chk(prescalerSelect, 11'h000);
		tick(30);
		chk(prescalerSelect, 11'h005);
		probeIdWr = 1'b1;
		tick(1);
		probeIdWr = 1'b0;
		chk(residualClear_r, 11'h001);
		cmdEnableRx = 1'b1;
		i_host.wrCmd(1'b0, 1'b0, 1);
		cmdEnableRx = 1'b0;
		tick(1);
		chk(receiverInhibited_r, 11'h000);
		rxSetPulse = 1'b1;
		tick(3);
		chk(receiverInhibited_r, 11'h000);
		rxSetPulse = 1'b0;
		tick(2);
		chk(receiverInhibited_r, 11'h001);
		refinementEnable = 1'b0;
		i_host.setSel(3'h2);
		tick(2);
		chk(prescalerSelect, 11'h002);
		arbMark = arbCnt;
		tick(64);
		chk(arbCnt - arbMark, 11'h008);
		slowArbitration = 1'b1;
		tick(8);
		arbMark = arbCnt;
		tick(64);
		chk(arbCnt - arbMark, 11'h004);
		i_host.wrId(8'h00);
		chk(softReset_r, 11'h001);
		tick(1);
		chk({transmitterAvailable_r, receiverInhibited_r}, 11'h003);
		tally_and_finish;
	end
endmodule // test_init_and_timing_refinement_ctl
